// ### vci_defines.svh
// Purpose: shared constants of the host command interpreter
// Assumes: byte-wide command port, 16-bit status and error words
// Notes:   definitions only
`ifndef VCI_DEFINES_SVH
`define VCI_DEFINES_SVH

// command opcodes
`define VCI_OP_STOP       8'h00
`define VCI_OP_SET_TAG    8'h05
`define VCI_OP_SAY_WORD   8'h07
`define VCI_OP_SET_SPEED  8'h16
`define VCI_OP_SAY_SENT   8'h1F
`define VCI_OP_SP_MODE    8'h2F
`define VCI_OP_MSG_PTR    8'h30

// status word fields
`define VCI_STAT_NORMAL_END 0
`define VCI_STATUS_RST      16'h0000

// error word fields
`define VCI_ERR_INVALID     0
`define VCI_PARAMETER_ERROR       1
`define VCI_ERROR_RST       16'h0000

// speed range, two's complement
`define VCI_SPEED_MIN       8'hFA
`define VCI_SPEED_MAX       8'h06
`define VCI_SPEED_RST       8'h00
// playback step at normal speed; larger is faster
`define VCI_RATE_NORMAL     8'h10

// highest speakerphone mode code and the reserved one
`define VCI_SP_CODE_MAX     8'h07
`define VCI_SP_CODE_RSVD    8'h05

`endif

// ### vci_pkg.sv
// Purpose: types of the host command interpreter
// Assumes: 24-bit message memory addresses
// Notes:   constants live in vci_defines.svh
package vci_pkg;

  localparam int ADDR_W = 24;

  // processor state, one-hot
  typedef enum logic [3:0] {
    ST_IDLE     = 4'b0001,
    ST_MESSAGE_OPEN_STATE = 4'b0010,
    ST_SYNTH    = 4'b0100,
    ST_PLAY     = 4'b1000
  } proc_state_t;

  // command byte parser, one-hot
  typedef enum logic [2:0] {
    P_OPCODE = 3'b001,
    P_ARG1   = 3'b010,
    P_ARG2   = 3'b100
  } parse_state_t;

  // speakerphone mode codes
  typedef enum logic [2:0] {
    SP_OFF     = 3'h0,
    SP_FULL    = 3'h1,
    SP_TRANSP  = 3'h2,
    SP_MUTE    = 3'h3,
    SP_LISTEN  = 3'h4,
    SP_RSVD    = 3'h5,
    SP_RESTART = 3'h6,
    SP_HOLD    = 3'h7
  } sp_mode_t;

  // one byte on the command port
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } cmd_byte_t;

  // current message as seen by the message manager
  typedef struct packed {
    logic              defined;
    logic [ADDR_W-1:0] start;
    logic [ADDR_W-1:0] length;
    logic [15:0]       tag;
  } msg_info_t;

  // current vocabulary limits
  typedef struct packed {
    logic       defined;
    logic [7:0] word_last;
    logic [7:0] ctrl_first;
    logic [7:0] sentence_last;
  } vocab_info_t;

  // request to the synthesiser
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       sentence;
    logic [7:0] index;
    logic [7:0] arg;
  } synth_req_t;

  // speakerphone controls
  typedef struct packed {
    sp_mode_t mode;
    logic     hold;
    logic     line_silence;
    logic     tone_det_en;
    logic     codec_int_en;
    logic     reinit;
    logic     restart;
  } sp_ctrl_t;

endpackage : vci_pkg

// ### vci_interp.sv
// Purpose: host command interpreter slice of the speech processor
// Assumes: host bytes arrive on core_clk, at most one per cycle
// Notes:   other opcodes are echoed and otherwise ignored, but set the invalid error while the speakerphone is on or held
`include "vci_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module vci_interp #(
  parameter int PAGE_BYTES = 32                      // bytes per message page
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_b,
  // command port
  input  wire vci_pkg::cmd_byte_t   cmd_in,
  output var  vci_pkg::cmd_byte_t   echo_out,
  // message and vocabulary context
  input  wire vci_pkg::msg_info_t   msg,
  input  wire vci_pkg::vocab_info_t vocab,
  input  wire logic                 pcm_data,
  // playback events from the wider unit
  input  wire logic                 synth_done,
  input  wire logic                 play_begin,
  input  wire logic                 play_end,
  // host acknowledges of status and error
  input  wire logic                 status_clear,
  input  wire logic                 error_clear,
  // state and message outputs
  output var  vci_pkg::proc_state_t proc_state,
  output var  logic [23:0]          msg_pointer,
  output var  logic                 tag_write,
  output var  logic [15:0]          tag_value,
  // synthesis and speed
  output var  vci_pkg::synth_req_t  synth,
  output var  logic [7:0]           speed,
  output var  logic [7:0]           speed_rate,
  // status, error and host request
  output var  logic [15:0]          status_word,
  output var  logic [15:0]          error_word,
  output var  logic                 host_request_n,
  // speakerphone
  output var  vci_pkg::sp_ctrl_t    sp
);
  import vci_pkg::*;

  localparam int PAGE_SHIFT = $clog2(PAGE_BYTES);

  // page size must be a power of two so that it is a shift; offset must fit 24 bits
  if (PAGE_BYTES < 1 || (1 << PAGE_SHIFT) != PAGE_BYTES || PAGE_SHIFT > 8) begin : g_bad_page
    $error("PAGE_BYTES must be a power of two up to 256");
  end

  // number of argument bytes that follow an opcode
  function automatic logic [1:0] arg_count(input logic [7:0] op);
    case (op)
      `VCI_OP_MSG_PTR, `VCI_OP_SET_TAG: arg_count = 2'd2;
      `VCI_OP_SAY_WORD, `VCI_OP_SET_SPEED,
      `VCI_OP_SAY_SENT, `VCI_OP_SP_MODE: arg_count = 2'd1;
      default:                           arg_count = 2'd0;
    endcase
  endfunction : arg_count

  // playback step for a speed setting; strictly falls as setting rises
  function automatic logic [7:0] rate_of(input logic [7:0] s);
    rate_of = 8'(`VCI_RATE_NORMAL - s);
  endfunction : rate_of

  // parser registers
  parse_state_t pstate, next_pstate;                 // byte position, now and next
  logic [7:0]   opcode;                              // held opcode
  logic [7:0]   arg_hi;                              // first argument byte

  // next values of the outputs
  proc_state_t next_state;
  logic [23:0] next_pointer;
  logic        next_tag_write, next_request_n;
  logic [15:0] next_tag_value;
  synth_req_t  next_synth;
  logic [7:0]  next_speed;
  logic [15:0] next_status, next_error;
  sp_ctrl_t    next_sp;

  // event strobes of this cycle
  logic set_end, set_invalid, set_param, raise_req;

  // byte decode
  wire        byte_in   = cmd_in.valid;
  wire [7:0]  byte_val  = cmd_in.data;
  wire [1:0]  op_args   = arg_count(byte_val);
  wire [1:0]  held_args = arg_count(opcode);
  wire        at_opcode = pstate == P_OPCODE;
  wire        at_arg1   = pstate == P_ARG1;
  wire        at_arg2   = pstate == P_ARG2;

  // last byte of a command completes it in the same cycle
  wire exec = byte_in && ((at_opcode && op_args == 2'd0) ||
                          (at_arg1 && held_args == 2'd1) || at_arg2);
  wire [7:0]  exec_op = at_opcode ? byte_val : opcode;
  wire [7:0]  arg8    = byte_val;
  // two-byte arguments arrive high byte first
  wire [15:0] arg16   = {arg_hi, byte_val};

  // context decode
  wire is_idle  = proc_state == ST_IDLE;
  wire sp_on    = sp.mode != SP_OFF || sp.hold;
  wire restrict_cmd = sp_on && exec_op != `VCI_OP_STOP && exec_op != `VCI_OP_SP_MODE;

  wire [23:0] page_off = 24'(arg16) << PAGE_SHIFT;
  wire        past_end = page_off > msg.length;

  // word outside table or a control code
  wire word_bad  = arg8 > vocab.word_last || arg8 >= vocab.ctrl_first;
  wire sent_bad  = arg8 > vocab.sentence_last;
  wire speed_bad = $signed(arg8) < $signed(`VCI_SPEED_MIN) ||
                   $signed(arg8) > $signed(`VCI_SPEED_MAX);
  wire mode_bad  = arg8 > `VCI_SP_CODE_MAX || arg8 == `VCI_SP_CODE_RSVD;
  wire [2:0] mode_code = arg8[2:0];

  // parser sequencing
  always_comb begin
    next_pstate = pstate;
    if (byte_in) begin
      unique case (pstate)
        P_OPCODE: next_pstate = (op_args == 2'd0) ? P_OPCODE : P_ARG1;
        P_ARG1:   next_pstate = (held_args == 2'd2) ? P_ARG2 : P_OPCODE;
        P_ARG2:   next_pstate = P_OPCODE;
      endcase
    end
  end

  // command execution and playback events
  always_comb begin
    next_state     = proc_state;
    next_pointer   = msg_pointer;
    next_tag_write = 1'b0;
    next_tag_value = tag_value;
    next_synth     = synth;
    next_synth.start = 1'b0;
    next_synth.stop  = 1'b0;
    next_speed     = speed;
    next_sp        = sp;
    next_sp.reinit  = 1'b0;
    next_sp.restart = 1'b0;
    set_end        = 1'b0;
    set_invalid    = 1'b0;
    set_param      = 1'b0;
    raise_req      = 1'b0;

    if (synth_done && proc_state == ST_SYNTH) begin
      next_state = ST_IDLE;
      set_end    = 1'b1;
      raise_req  = 1'b1;
    end
    // playback state follows the wider unit
    if (play_begin && is_idle) begin
      next_state = ST_PLAY;
    end
    if (play_end && proc_state == ST_PLAY) begin
      next_state = ST_IDLE;
    end

    // a completed command overrides events of the same cycle
    if (exec) begin
      if (restrict_cmd) begin
        set_invalid = 1'b1;
      end else begin
        case (exec_op)
          `VCI_OP_STOP: begin
            next_state      = ST_IDLE;
            next_synth.stop = 1'b1;
          end
          `VCI_OP_MSG_PTR: begin
            if (!msg.defined) begin
              set_invalid = 1'b1;
            end else if (past_end) begin
              next_pointer = msg.start + msg.length;
              set_end      = 1'b1;
              next_state   = ST_IDLE;
            end else begin
              next_pointer = msg.start + page_off;
              if (is_idle) begin
                next_state = ST_MESSAGE_OPEN_STATE;
              end
            end
          end
          `VCI_OP_SET_TAG: begin
            if (!msg.defined) begin
              set_invalid = 1'b1;
            end else begin
              next_tag_value = msg.tag & arg16;
              next_tag_write = 1'b1;
            end
          end
          `VCI_OP_SAY_WORD, `VCI_OP_SAY_SENT: begin
            if (!vocab.defined || !is_idle) begin
              set_invalid = 1'b1;
            end else if (exec_op == `VCI_OP_SAY_WORD ? word_bad : sent_bad) begin
              set_param = 1'b1;
            end else begin
              next_state          = ST_SYNTH;
              next_synth.start    = 1'b1;
              next_synth.sentence = exec_op == `VCI_OP_SAY_SENT;
              next_synth.index    = arg8;
              next_synth.arg      = 8'h00;
            end
          end
          `VCI_OP_SET_SPEED: begin
            if (speed_bad) begin
              set_param = 1'b1;
            end else begin
              next_speed = arg8;
            end
          end
          `VCI_OP_SP_MODE: begin
            if (!is_idle) begin
              set_invalid = 1'b1;
            end else if (mode_bad) begin
              set_param = 1'b1;
            end else if (mode_code == SP_HOLD) begin
              next_sp.hold = 1'b1;
            end else if (mode_code == SP_RESTART) begin
              next_sp.hold    = 1'b0;
              next_sp.restart = 1'b1;
            end else begin
              next_sp.mode   = sp_mode_t'(mode_code);
              next_sp.hold   = 1'b0;
              next_sp.reinit = mode_code != SP_OFF;
            end
          end
          default: begin
            // commands outside this slice are only echoed
          end
        endcase
      end
    end

    next_sp.line_silence = next_sp.mode == SP_MUTE || next_sp.hold;
    next_sp.tone_det_en  = next_sp.mode != SP_FULL && next_sp.mode != SP_MUTE && !next_sp.hold;
    next_sp.codec_int_en = !next_sp.hold;
  end

  // sticky words: a set in the clearing cycle survives
  always_comb begin
    next_status = status_clear ? `VCI_STATUS_RST : status_word;
    next_error  = error_clear ? `VCI_ERROR_RST : error_word;
    next_status[`VCI_STAT_NORMAL_END] = next_status[`VCI_STAT_NORMAL_END] | set_end;
    next_error[`VCI_ERR_INVALID]      = next_error[`VCI_ERR_INVALID] | set_invalid;
    next_error[`VCI_PARAMETER_ERROR]        = next_error[`VCI_PARAMETER_ERROR] | set_param;
    // request held low until status read
    next_request_n = raise_req ? 1'b0 : (status_clear ? 1'b1 : host_request_n);
  end

  // parser registers and byte echo
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pstate   <= P_OPCODE;
      opcode   <= 8'h00;
      arg_hi   <= 8'h00;
      echo_out <= '0;
    end else begin
      pstate   <= next_pstate;
      if (byte_in && at_opcode) begin
        opcode <= byte_val;
      end
      if (byte_in && at_arg1) begin
        arg_hi <= byte_val;
      end
      // echo every byte one cycle later
      echo_out <= cmd_in;
    end
  end

  // processor state, message, synthesis and speed outputs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      proc_state  <= ST_IDLE;
      msg_pointer <= 24'h00_0000;
      tag_write   <= 1'b0;
      tag_value   <= 16'h0000;
      synth       <= '0;
      speed       <= `VCI_SPEED_RST;
      speed_rate  <= `VCI_RATE_NORMAL;
    end else begin
      proc_state  <= next_state;
      msg_pointer <= next_pointer;
      tag_write   <= next_tag_write;
      tag_value   <= next_tag_value;
      synth       <= next_synth;
      speed       <= next_speed;
      // rate tracks setting at once; neutral for PCM
      speed_rate  <= pcm_data ? rate_of(`VCI_SPEED_RST) : rate_of(next_speed);
    end
  end

  // status, error, request and speakerphone
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_word    <= `VCI_STATUS_RST;
      error_word     <= `VCI_ERROR_RST;
      host_request_n <= 1'b1;
      sp             <= '{mode: SP_OFF, hold: 1'b0, line_silence: 1'b0,
                          tone_det_en: 1'b1, codec_int_en: 1'b1,
                          reinit: 1'b0, restart: 1'b0};
    end else begin
      status_word    <= next_status;
      error_word     <= next_error;
      host_request_n <= next_request_n;
      sp             <= next_sp;
    end
  end

endmodule : vci_interp
`default_nettype wire

// ### vci_interp_asserts.sv
// Purpose: port assertions of the command interpreter
// Assumes: one clock domain, reset active low
// Notes:   bound onto vci_interp at the foot of this file
`timescale 1ns/100ps
`default_nettype none

module vci_interp_asserts (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  // watched inputs
  input wire vci_pkg::cmd_byte_t   cmd_in,
  input wire vci_pkg::msg_info_t   msg,
  input wire logic                 pcm_data,
  input wire logic                 synth_done,
  // watched outputs
  input wire vci_pkg::cmd_byte_t   echo_out,
  input wire vci_pkg::proc_state_t proc_state,
  input wire logic                 tag_write,
  input wire logic [15:0]          tag_value,
  input wire vci_pkg::synth_req_t  synth,
  input wire logic [7:0]           speed,
  input wire logic [7:0]           speed_rate,
  input wire logic [15:0]          status_word,
  input wire logic                 host_request_n,
  input wire vci_pkg::sp_ctrl_t    sp
);
  import vci_pkg::*;
  // all checks on the core clock, quiet in reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_echo; cmd_in.valid |=> echo_out.valid && echo_out.data == $past(cmd_in.data); endproperty
  a_echo: assert property (p_echo) else $error("echo lost or altered");
  property p_done; synth_done && proc_state == ST_SYNTH && !cmd_in.valid
    |=> proc_state == ST_IDLE && status_word[0] && !host_request_n; endproperty
  a_done: assert property (p_done) else $error("synthesis end not reported");
  property p_req; !host_request_n |-> status_word[0]; endproperty
  a_req: assert property (p_req) else $error("request without end flag");
  property p_range; speed <= 8'h06 || speed >= 8'hfa; endproperty
  a_range: assert property (p_range) else $error("speed out of range");
  property p_rate; speed_rate == ($past(pcm_data) ? 8'h10 : 8'(8'h10 - speed)); endproperty
  a_rate: assert property (p_rate) else $error("playback step wrong");
  property p_tag; tag_write |-> (tag_value & ~$past(msg.tag)) == 16'h0000; endproperty
  a_tag: assert property (p_tag) else $error("tag bit was set");
  property p_sp_idle; $changed(sp.mode) |-> $past(proc_state) == ST_IDLE; endproperty
  a_sp_idle: assert property (p_sp_idle) else $error("mode changed outside idle");
  property p_quiet; sp.mode inside {SP_FULL, SP_MUTE}
    |-> !sp.tone_det_en && sp.line_silence == (sp.mode == SP_MUTE || sp.hold); endproperty
  a_quiet: assert property (p_quiet) else $error("detector or silence wrong");
  property p_hold; sp.hold |-> !sp.codec_int_en; endproperty
  a_hold: assert property (p_hold) else $error("codec interrupts in hold");
  property p_start; synth.start |-> proc_state == ST_SYNTH && (!synth.sentence || synth.arg == 8'h00); endproperty
  a_start: assert property (p_start) else $error("synthesis start wrong");
endmodule : vci_interp_asserts

bind vci_interp vci_interp_asserts i_chk (
  .core_clk(core_clk), .rst_b(rst_b), .cmd_in(cmd_in), .msg(msg), .pcm_data(pcm_data),
  .synth_done(synth_done), .echo_out(echo_out), .proc_state(proc_state), .tag_write(tag_write),
  .tag_value(tag_value), .synth(synth), .speed(speed), .speed_rate(speed_rate),
  .status_word(status_word), .host_request_n(host_request_n), .sp(sp)
);

`default_nettype wire

// ### vci_host_model.sv
// Purpose: host microcontroller on the command port
// Assumes: bytes launched on the falling clock edge
// Notes:   a released port shows inverted data, never a stale byte
`timescale 1ns/100ps
`default_nettype none

module vci_host_model (
  // clock
  input wire logic               core_clk,
  // command port towards the device
  output var vci_pkg::cmd_byte_t cmd_in
);
  import vci_pkg::*;
  initial cmd_in = '0;  // port idle at time zero

  // one byte per cycle; calls in a row go back to back
  task put(input logic [7:0] b);
    @(negedge core_clk);
    cmd_in.valid = 1'b1;
    cmd_in.data  = b;
  endtask : put

  // release the port; scramble data so nothing stale is seen
  task idle();
    @(negedge core_clk);
    cmd_in.valid = 1'b0;
    cmd_in.data  = ~cmd_in.data;
  endtask : idle

  // whole command: opcode, high byte first, then release
  task send(input logic [7:0] op, input int n, input logic [15:0] a);
    put(op);
    if (n == 2) put(a[15:8]);
    if (n > 0) put(a[7:0]);
    idle();
  endtask : send
endmodule : vci_host_model

`default_nettype wire

// ### vci_interp_tb.sv
// Purpose: self-checking bench of the command interpreter
// Assumes: inputs change on the falling edge
// Notes:   random values from a fixed seed
`timescale 1ns/100ps
`default_nettype none

module vci_interp_tb;
  import vci_pkg::*;
  logic        core_clk = 1'b0;  // 40 MHz
  logic        rst_b = 1'b0;     // held low at start
  cmd_byte_t   cmd_in;           // driven by host model
  cmd_byte_t   echo_out;
  msg_info_t   msg = '{1'b1, 24'h00_0100, 24'h00_1000, 16'h0000};
  vocab_info_t vocab = '{1'b1, 8'h28, 8'h1e, 8'h09};
  logic        pcm_data = 1'b0, synth_done = 1'b0, play_begin = 1'b0, play_end = 1'b0;
  logic        status_clear = 1'b0, error_clear = 1'b0;
  proc_state_t proc_state;
  logic [23:0] msg_pointer;
  logic        tag_write, host_request_n;
  logic [15:0] tag_value, status_word, error_word, pc, w;
  synth_req_t  synth;
  sp_ctrl_t    sp;
  logic [7:0]  speed, speed_rate, idx, op, ev8;
  logic [2:0]  em;               // expected mode
  logic        ok;
  logic [7:0]  tbl [6] = '{8'h00, 8'h00, 8'h1d, 8'h1e, 8'h29, 8'hff};
  int          seed, error_cnt = 0, tests_run = 0;

  vci_host_model i_host (.core_clk(core_clk), .cmd_in(cmd_in));
  vci_interp #(.PAGE_BYTES(32)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .cmd_in(cmd_in), .echo_out(echo_out), .msg(msg),
    .vocab(vocab), .pcm_data(pcm_data), .synth_done(synth_done), .play_begin(play_begin),
    .play_end(play_end), .status_clear(status_clear), .error_clear(error_clear),
    .proc_state(proc_state), .msg_pointer(msg_pointer), .tag_write(tag_write),
    .tag_value(tag_value), .synth(synth), .speed(speed), .speed_rate(speed_rate),
    .status_word(status_word), .error_word(error_word), .host_request_n(host_request_n), .sp(sp)
  );

  // free-running clock
  always #12.5 core_clk = ~core_clk;

  // compare and count
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // acknowledge status and error words
  task clr();
    @(negedge core_clk);
    {status_clear, error_clear} = 2'b11;
    @(negedge core_clk);
    {status_clear, error_clear} = 2'b00;
  endtask : clr

  // one-cycle event: 0 synthesis done, 1 play begin, 2 play end
  task ev(input int k);
    @(negedge core_clk);
    {synth_done, play_begin, play_end} = 3'b100 >> k;
    @(negedge core_clk);
    {synth_done, play_begin, play_end} = 3'b000;
  endtask : ev

  // pointer clamps at message end past the length
  function automatic logic [23:0] exp_ptr(input logic [15:0] p);
    logic [31:0] off;
    off = {16'h0000, p} * 32;
    if (off > {8'h00, msg.length}) return msg.start + msg.length;
    return msg.start + off[23:0];
  endfunction : exp_ptr

  // verdict, one place for every ending
  task results();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    results();
  end

  initial begin
    seed = 32'h0130_93d0;
    repeat (20) @(posedge core_clk);
    @(negedge core_clk) rst_b = 1'b1;
    chk("state", proc_state, ST_IDLE);
    chk("request", host_request_n, 1'b1);
    $display("test reset done");
    // exact end, one page past it, random counts
    for (int i = 0; i < 7; i++) begin
      pc = (i == 0) ? 16'h000a : (i == 1) ? 16'h0080 : (i == 2) ? 16'h0081 : 16'($random(seed)) & 16'h00ff;
      i_host.send(8'h30, 2, pc);
      ok = ({16'h0000, pc} * 32) > {8'h00, msg.length};
      chk("pointer", msg_pointer, exp_ptr(pc));
      chk("state", proc_state, ok ? ST_IDLE : ST_MESSAGE_OPEN_STATE);
      chk("end flag", status_word[0], ok);
      chk("echo", echo_out, {1'b1, pc[7:0]});
      i_host.send(8'h00, 0, 16'h0000);
      chk("state", proc_state, ST_IDLE);
      chk("stop", synth.stop, 1'b1);
      clr();
    end
    // no current message
    msg.defined = 1'b0;
    for (int i = 0; i < 2; i++) begin
      i_host.send(i ? 8'h05 : 8'h30, 2, 16'h0001);
      chk("invalid", error_word[0], 1'b1);
      clr();
    end
    msg.defined = 1'b1;
    $display("test message done");
    // tag merge, first pass read-modify-write of bit 3
    for (int i = 0; i < 5; i++) begin
      msg.tag = 16'($random(seed));
      w = (i == 0) ? msg.tag & 16'hfff7 : 16'($random(seed));
      i_host.send(8'h05, 2, w);
      chk("tag write", tag_write, 1'b1);
      chk("tag", tag_value, msg.tag & w);
    end
    $display("test tag done");
    // words then sentences, edges of ranges and control codes
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 6; i++) begin
        idx = (i == 1) ? 8'($random(seed)) & 8'h1f : tbl[i];
        op = s ? 8'h1f : 8'h07;
        ok = s ? idx <= vocab.sentence_last : idx <= vocab.word_last && idx < vocab.ctrl_first;
        i_host.send(op, 1, {8'h00, idx});
        chk("param", error_word[1], !ok);
        if (ok) begin
          chk("start", {synth.start, synth.sentence, synth.index}, {1'b1, s[0], idx});
          chk("state", proc_state, ST_SYNTH);
          ev(0);
          chk("done", {proc_state, status_word[0], host_request_n}, {ST_IDLE, 2'b10});
        end
        clr();
        chk("request", host_request_n, 1'b1);
      end
    end
    vocab.defined = 1'b0;
    for (int i = 0; i < 2; i++) begin
      i_host.send(i ? 8'h1f : 8'h07, 1, 16'h0000);
      chk("invalid", error_word[0], 1'b1);
      clr();
    end
    vocab.defined = 1'b1;
    $display("test synthesis done");
    // every speed -8..8, out-of-range keeps the last good one
    ev8 = 8'h00;
    for (int v = -8; v <= 8; v++) begin
      i_host.send(8'h16, 1, 16'(v));
      ok = v >= -6 && v <= 6;
      if (ok) ev8 = 8'(v);
      chk("speed", speed, ev8);
      chk("param", error_word[1], !ok);
      @(negedge core_clk);
      chk("rate", speed_rate, 8'(8'h10 - ev8));
      clr();
    end
    pcm_data = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("pcm rate", speed_rate, 8'h10);
    pcm_data = 1'b0;
    ev(1);
    chk("state", proc_state, ST_PLAY);
    i_host.send(8'h16, 1, 16'h00fb);
    @(negedge core_clk);
    chk("play rate", speed_rate, 8'h15);
    i_host.send(8'h2f, 1, 16'h0001);
    chk("invalid", {error_word[0], sp.mode}, {1'b1, SP_OFF});
    ev(2);
    clr();
    $display("test speed done");
    // every mode code, then one above the range
    em = 3'h0;
    for (int m = 0; m < 9; m++) begin
      i_host.send(8'h2f, 1, 16'(m));
      if (m < 5) em = 3'(m);
      chk("mode", sp.mode, em);
      chk("param", error_word[1], m == 5 || m == 8);
      if (m == 6) chk("restart", sp.restart, 1'b1);
      if (m == 7) chk("hold", sp.hold, 1'b1);
      if (m == 4) chk("detectors", {sp.tone_det_en, sp.line_silence}, 2'b10);
      chk("reinit", sp.reinit, m >= 1 && m <= 4);
      clr();
    end
    i_host.send(8'h16, 1, 16'h0001);
    chk("restricted", {error_word[0], speed}, {1'b1, 8'hfb});
    i_host.send(8'h2f, 1, 16'h0006);
    i_host.send(8'h2f, 1, 16'h0000);
    chk("off", {sp.mode, sp.hold}, 4'h0);
    clr();
    $display("test speakerphone done");
    // reset again in mid-run
    rst_b = 1'b0;
    repeat (2) @(negedge core_clk);
    rst_b = 1'b1;
    chk("state", {proc_state, speed}, {ST_IDLE, 8'h00});
    $display("test second reset done");
    results();
  end
endmodule : vci_interp_tb

`default_nettype wire
